// ### hw/fss_bank.sv
// fault status summary bank: sticky status flags, summary word and clear-all command
// assumes a protocol layer delivering one command pulse per transaction, a page
// value kept elsewhere, and fault detectors driving condition levels on clk
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// (RULE1) send-byte 0x03 clears unpaged flags and selected page's paged flags
// (RULE2) clear-all releases this device's alert contribution in the same cycle; here alert_out_n_oe comes from alert_reg and drops one cycle later
// (RULE3) clear-all never restarts a latched-off channel; only flags and alert
// (RULE4) a condition still present after clearing sets its flag and alert again
// (RULE5) clear-all with page 0xff acts on all four channels
// (RULE6) read-byte 0x78 returns the very low byte of the summary word
// (RULE7) read-word 0x79 returns the selected channel's 16-bit summary
// (RULE8) bits 15..12 flag vout, iout, input, vendor fault or warning
// (RULE9) bit 11 flags power not good while power good is enabled and low
// (RULE10) bits 10..8 always read zero
// (RULE11) bit 7 flags a command received while busy
// (RULE12) bit 6 set while channel supplies no output power, clear otherwise
// (RULE13) bits 5..3 flag output overvoltage, overcurrent, input undervoltage faults
// (RULE14) bit 2 flags any temperature fault or warning
// (RULE15) bit 1 flags any communication, memory or logic fault
// (RULE16) bit 0 flags other faults in the upper byte or power not good
// (RULE17) vout, iout, temperature flags are paged read-byte at 0x7a, 0x7b, 0x7d
// (RULE18) input flags 0x7c and comm flags 0x7e are unpaged read-byte
// (RULE19) paged read-byte 0x80 gives per-channel vendor fault and state flags
// (RULE20) unpaged read/write word 0xe5 shows present digital pad state
// (RULE21) unpaged read-byte 0xef gives family-common status bits
// (RULE22) shared-fault shutoff drives alert low and sets the vendor flag
// (RULE23) fault and warning flags are sticky until clear-all
// (RULE24) paged flags have one copy per channel, chosen by page on reads
module fss_bank
   import fss_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset,
   // command port from the protocol layer
   input  wire logic                 cmd_valid,
   input  wire logic [1:0]           cmd_op,
   input  wire logic [7:0]           cmd_code,
   input  wire logic [15:0]          cmd_wdata,
   input  wire logic [7:0]           page_sel,
   // answer to the protocol layer
   output logic                      rsp_valid,
   output logic [15:0]               rsp_data,
   output logic                      rsp_word,
   output logic                      rsp_refused,
   // fault conditions, levels, one byte per channel where paged
   input  wire logic [3:0][7:0]      vout_cond,
   input  wire logic [3:0][7:0]      iout_cond,
   input  wire logic [3:0][7:0]      temp_cond,
   input  wire logic [3:0][7:0]      vendor_cond,
   input  wire logic [7:0]           input_cond,
   input  wire logic [7:0]           cml_cond,
   input  wire logic                 busy_cmd_seen,
   // shared fault pin shutoffs, per channel
   input  wire logic [3:0]           shared_fault0_shutoff,
   input  wire logic [3:0]           shared_fault1_shutoff,
   // channel state
   input  wire logic [3:0]           chan_output_off,
   input  wire logic [3:0]           power_good_enable,
   input  wire logic [3:0]           power_good_out,
   // pads and common status
   input  wire logic [15:0]          pad_pins,
   output logic [15:0]               pad_write_value,
   input  wire logic [7:0]           common_status,
   // shared open-drain alert
   output logic                      alert_out_n,
   output logic                      alert_out_n_oe
);

   // command decode
   wire logic       op_send;
   wire logic       op_read;
   wire logic       op_write;
   wire logic       clear_cmd;
   wire logic       page_all;
   wire logic       page_ok;
   wire logic [1:0] page_idx;

   assign op_send   = cmd_valid && (cmd_op == OP_SEND);
   assign op_read   = cmd_valid && (cmd_op == OP_READ);
   assign op_write  = cmd_valid && (cmd_op == OP_WRITE);
   assign clear_cmd = op_send && (cmd_code == CMD_CLEAR); // [RULE1]
   assign page_all  = (page_sel == PAGE_ALL);
   assign page_ok   = (page_sel < 8'h04);
   assign page_idx  = page_sel[1:0];

   // sticky flag storage
   logic [7:0] vout_reg   [NUM_CHAN];
   logic [7:0] iout_reg   [NUM_CHAN];
   logic [7:0] temp_reg   [NUM_CHAN];
   logic [7:0] vendor_reg [NUM_CHAN];
   logic [7:0] input_reg;
   logic [7:0] cml_reg;
   logic       busy_reg;
   logic       alert_reg;

   logic [7:0] vout_next   [NUM_CHAN];
   logic [7:0] iout_next   [NUM_CHAN];
   logic [7:0] temp_next   [NUM_CHAN];
   logic [7:0] vendor_next [NUM_CHAN];
   logic [NUM_CHAN-1:0] chan_new;
   logic [NUM_CHAN-1:0] chan_clr;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch++)
      begin : g_chan
         wire logic [7:0] vout_set;
         wire logic [7:0] iout_set;
         wire logic [7:0] temp_set;
         wire logic [7:0] vendor_set;
         wire logic [7:0] shut_bits;
         wire logic [7:0] vout_keep;
         wire logic [7:0] iout_keep;
         wire logic [7:0] temp_keep;
         wire logic [7:0] vendor_keep;

         // clear this channel when selected, or every channel on the global page
         assign chan_clr[ch] = clear_cmd && (page_all || (page_ok && page_idx == ch)); // [RULE1] [RULE5]

         assign shut_bits = ({7'h00, shared_fault0_shutoff[ch]} << MFR_SHUT0_BIT)
                          | ({7'h00, shared_fault1_shutoff[ch]} << MFR_SHUT1_BIT); // [RULE22]

         assign vout_set   = vout_cond[ch] & VOUT_MASK;
         assign iout_set   = iout_cond[ch] & IOUT_MASK;
         assign temp_set   = temp_cond[ch] & TEMP_MASK;
         assign vendor_set = (vendor_cond[ch] | shut_bits) & MFR_MASK;

         assign vout_keep   = chan_clr[ch] ? FLAG_RESET : vout_reg[ch];
         assign iout_keep   = chan_clr[ch] ? FLAG_RESET : iout_reg[ch];
         assign temp_keep   = chan_clr[ch] ? FLAG_RESET : temp_reg[ch];
         assign vendor_keep = chan_clr[ch] ? FLAG_RESET : vendor_reg[ch];

         // set wins over clear, so a lasting condition re-latches at once
         assign vout_next[ch]   = vout_keep | vout_set;     // [RULE4] [RULE23]
         assign iout_next[ch]   = iout_keep | iout_set;     // [RULE4] [RULE23]
         assign temp_next[ch]   = temp_keep | temp_set;     // [RULE4] [RULE23]
         assign vendor_next[ch] = vendor_keep | vendor_set; // [RULE4] [RULE23]

         // a bit that is newly set raises the alert
         assign chan_new[ch] = |((vout_set & ~vout_keep) | (iout_set & ~iout_keep)
                              | (temp_set & ~temp_keep) | (vendor_set & ~vendor_keep));

         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
            begin
               vout_reg[ch]   <= FLAG_RESET;
               iout_reg[ch]   <= FLAG_RESET;
               temp_reg[ch]   <= FLAG_RESET;
               vendor_reg[ch] <= FLAG_RESET;
            end
            else
            begin
               vout_reg[ch]   <= vout_next[ch];   // [RULE24]
               iout_reg[ch]   <= iout_next[ch];   // [RULE24]
               temp_reg[ch]   <= temp_next[ch];   // [RULE24]
               vendor_reg[ch] <= vendor_next[ch]; // [RULE24]
            end
         end
      end
   endgenerate

   // unpaged flags are cleared by any clear-all, whatever the page
   wire logic [7:0] input_set;
   wire logic [7:0] cml_set;
   wire logic [7:0] input_keep;
   wire logic [7:0] cml_keep;
   wire logic       busy_keep;
   wire logic       unpaged_new;
   wire logic       alert_next;

   assign input_set   = input_cond & INPUT_MASK;
   assign cml_set     = cml_cond & CML_MASK;
   assign input_keep  = clear_cmd ? FLAG_RESET : input_reg; // [RULE1]
   assign cml_keep    = clear_cmd ? FLAG_RESET : cml_reg;   // [RULE1]
   assign busy_keep   = clear_cmd ? 1'b0 : busy_reg;        // [RULE1]
   assign unpaged_new = |((input_set & ~input_keep) | (cml_set & ~cml_keep))
                      | (busy_cmd_seen & ~busy_keep);

   // clear releases the alert; a fresh or persisting condition drives it again
   assign alert_next = ((clear_cmd ? 1'b0 : alert_reg) | unpaged_new | (|chan_new)); // [RULE2] [RULE4] [RULE22]

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         input_reg <= FLAG_RESET;
         cml_reg   <= FLAG_RESET;
         busy_reg  <= 1'b0;
         alert_reg <= 1'b0;
      end
      else
      begin
         input_reg <= input_keep | input_set;          // [RULE23]
         cml_reg   <= cml_keep | cml_set;              // [RULE23]
         busy_reg  <= busy_keep | busy_cmd_seen;       // [RULE11]
         alert_reg <= alert_next;
      end
   end

   // open drain: only ever pulls low
   assign alert_out_n    = 1'b0;
   assign alert_out_n_oe = alert_reg; // [RULE2]
   // chan_output_off comes from the sequencer and is only read here: clearing
   // flags cannot restart a latched-off channel [RULE3]

   // summary word of the selected channel
   wire logic        out_overvoltage_flag;
   wire logic        out_overcurrent_flag;
   wire logic        in_undervoltage_flag;
   wire logic        sel_png;
   wire logic [7:0]  sel_vout;
   wire logic [7:0]  sel_iout;
   wire logic [7:0]  sel_temp;
   wire logic [7:0]  sel_vendor;
   wire logic [15:0] summary_word;
   wire logic [7:0]  summary_byte;

   assign sel_vout   = vout_reg[page_idx];   // [RULE24]
   assign sel_iout   = iout_reg[page_idx];   // [RULE24]
   assign sel_temp   = temp_reg[page_idx];   // [RULE24]
   assign sel_vendor = vendor_reg[page_idx]; // [RULE24]

   assign out_overvoltage_flag = sel_vout[VOUT_OV_BIT];    // [RULE13]
   assign out_overcurrent_flag = sel_iout[IOUT_OC_BIT];    // [RULE13]
   assign in_undervoltage_flag = input_reg[INPUT_UV_BIT];  // [RULE13]
   assign sel_png = power_good_enable[page_idx] & ~power_good_out[page_idx]; // [RULE9]

   assign summary_word[SW_VOUT]    = |sel_vout;    // [RULE8]
   assign summary_word[SW_IOUT]    = |sel_iout;    // [RULE8]
   assign summary_word[SW_INPUT]   = |input_reg;   // [RULE8]
   assign summary_word[SW_MFR]     = |sel_vendor;  // [RULE8]
   assign summary_word[SW_PNG]     = sel_png;      // [RULE9]
   assign summary_word[10:8]       = 3'h0;         // [RULE10]
   assign summary_word[SW_BUSY]    = busy_reg;     // [RULE11]
   assign summary_word[SW_OFF]     = chan_output_off[page_idx]; // [RULE12]
   assign summary_word[SW_VOUT_OV] = out_overvoltage_flag;
   assign summary_word[SW_IOUT_OC] = out_overcurrent_flag;
   assign summary_word[SW_VIN_UV]  = in_undervoltage_flag;
   assign summary_word[SW_TEMP]    = |sel_temp;    // [RULE14]
   assign summary_word[SW_CML]     = |cml_reg;     // [RULE15]
   // upper byte conditions are not all covered by bits 7..1, so fold them here
   assign summary_word[SW_HIGH]    = |summary_word[15:8]; // [RULE16]

   // the byte read is a slice of the same wire, so the two can never disagree
   assign summary_byte = summary_word[7:0]; // [RULE6]

   // pad pins come from outside, two flops before use
   logic [15:0] pad_meta_reg;
   logic [15:0] pad_sync_reg;
   logic [15:0] pad_write_reg;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         pad_meta_reg <= PAD_RESET;
         pad_sync_reg <= PAD_RESET;
      end
      else
      begin
         pad_meta_reg <= pad_pins;
         pad_sync_reg <= pad_meta_reg;
      end
   end

   // read decode
   wire logic        hit_byte;
   wire logic        hit_word;
   wire logic        hit_paged;
   wire logic        hit_unpaged;
   wire logic        pad_wr;
   wire logic        read_ok;
   wire logic        cmd_ok;
   wire logic        rsp_is_word;
   wire logic [15:0] read_value;

   assign hit_paged   = (cmd_code == CMD_SUM_BYTE) || (cmd_code == CMD_SUM_WORD)
                      || (cmd_code == CMD_VOUT) || (cmd_code == CMD_IOUT)
                      || (cmd_code == CMD_TEMP) || (cmd_code == CMD_VENDOR); // [RULE17] [RULE19]
   assign hit_unpaged = (cmd_code == CMD_INPUT) || (cmd_code == CMD_CML)
                      || (cmd_code == CMD_PADS) || (cmd_code == CMD_COMMON); // [RULE18]
   assign hit_word    = (cmd_code == CMD_SUM_WORD) || (cmd_code == CMD_PADS);
   assign hit_byte    = hit_paged || hit_unpaged;
   // paged reads need a single real channel; the global page has no one copy
   assign read_ok     = op_read && hit_byte && (hit_unpaged || page_ok);
   assign pad_wr      = op_write && (cmd_code == CMD_PADS); // [RULE20]
   assign cmd_ok      = read_ok || pad_wr || clear_cmd;
   assign rsp_is_word = op_read && hit_word;

   assign read_value =
        (cmd_code == CMD_SUM_WORD) ? summary_word                     // [RULE7]
      : (cmd_code == CMD_SUM_BYTE) ? {8'h00, summary_byte}            // [RULE6]
      : (cmd_code == CMD_VOUT)     ? {8'h00, sel_vout}                // [RULE17]
      : (cmd_code == CMD_IOUT)     ? {8'h00, sel_iout}                // [RULE17]
      : (cmd_code == CMD_TEMP)     ? {8'h00, sel_temp}                // [RULE17]
      : (cmd_code == CMD_INPUT)    ? {8'h00, input_reg}               // [RULE18]
      : (cmd_code == CMD_CML)      ? {8'h00, cml_reg}                 // [RULE18]
      : (cmd_code == CMD_VENDOR)   ? {8'h00, sel_vendor}              // [RULE19]
      : (cmd_code == CMD_PADS)     ? pad_sync_reg                     // [RULE20]
      : (cmd_code == CMD_COMMON)   ? {8'h00, common_status}           // [RULE21]
      : DATA_RESET;

   logic        rsp_valid_reg;
   logic [15:0] rsp_data_reg;
   logic        rsp_word_reg;
   logic        rsp_refused_reg;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rsp_valid_reg   <= 1'b0;
         rsp_data_reg    <= DATA_RESET;
         rsp_word_reg    <= 1'b0;
         rsp_refused_reg <= 1'b0;
         pad_write_reg   <= PAD_RESET;
      end
      else
      begin
         rsp_valid_reg   <= cmd_valid;
         rsp_data_reg    <= read_ok ? read_value : DATA_RESET;
         rsp_word_reg    <= rsp_is_word;
         rsp_refused_reg <= cmd_valid && !cmd_ok;
         pad_write_reg   <= pad_wr ? cmd_wdata : pad_write_reg; // [RULE20]
      end
   end

   assign rsp_valid       = rsp_valid_reg;
   assign rsp_data        = rsp_data_reg;
   assign rsp_word        = rsp_word_reg;
   assign rsp_refused     = rsp_refused_reg;
   assign pad_write_value = pad_write_reg;

endmodule

`default_nettype wire

// ### hw/fss_pkg.sv
// constants for the fault status summary bank: command codes, bit positions, masks
// assumes a protocol layer that decodes bus transactions into command pulses
package fss_pkg;
   localparam int          NUM_CHAN        = 4;
   localparam logic [7:0]  PAGE_ALL        = 8'hff;
   localparam logic [7:0]  CMD_CLEAR       = 8'h03;
   localparam logic [7:0]  CMD_SUM_BYTE    = 8'h78;
   localparam logic [7:0]  CMD_SUM_WORD    = 8'h79;
   localparam logic [7:0]  CMD_VOUT        = 8'h7a;
   localparam logic [7:0]  CMD_IOUT        = 8'h7b;
   localparam logic [7:0]  CMD_INPUT       = 8'h7c;
   localparam logic [7:0]  CMD_TEMP        = 8'h7d;
   localparam logic [7:0]  CMD_CML         = 8'h7e;
   localparam logic [7:0]  CMD_VENDOR      = 8'h80;
   localparam logic [7:0]  CMD_PADS        = 8'he5;
   localparam logic [7:0]  CMD_COMMON      = 8'hef;
   // summary word positions
   localparam int          SW_VOUT         = 15;
   localparam int          SW_IOUT         = 14;
   localparam int          SW_INPUT        = 13;
   localparam int          SW_MFR          = 12;
   localparam int          SW_PNG          = 11;
   localparam int          SW_BUSY         = 7;
   localparam int          SW_OFF          = 6;
   localparam int          SW_VOUT_OV      = 5;
   localparam int          SW_IOUT_OC      = 4;
   localparam int          SW_VIN_UV       = 3;
   localparam int          SW_TEMP         = 2;
   localparam int          SW_CML          = 1;
   localparam int          SW_HIGH         = 0;
   // detailed register positions feeding the summary
   localparam int          VOUT_OV_BIT     = 7;
   localparam int          IOUT_OC_BIT     = 7;
   localparam int          INPUT_UV_BIT    = 4;
   localparam int          MFR_SHUT0_BIT   = 0;
   localparam int          MFR_SHUT1_BIT   = 1;
   // implemented bits of each detailed register, the rest read zero
   localparam logic [7:0]  VOUT_MASK       = 8'hfc;
   localparam logic [7:0]  IOUT_MASK       = 8'hb0;
   localparam logic [7:0]  INPUT_MASK      = 8'hf8;
   localparam logic [7:0]  TEMP_MASK       = 8'hf0;
   localparam logic [7:0]  CML_MASK        = 8'hff;
   localparam logic [7:0]  MFR_MASK        = 8'hff;
   localparam logic [7:0]  FLAG_RESET      = 8'h00;
   localparam logic [15:0] PAD_RESET       = 16'h0000;
   localparam logic [15:0] DATA_RESET      = 16'h0000;

   typedef enum logic [1:0]
   {
      OP_SEND  = 2'b00,
      OP_READ  = 2'b01,
      OP_WRITE = 2'b10,
      OP_RSVD  = 2'b11
   } fss_op_type;
endpackage

// ### verification/fss_bank_sva.sv
// assertions on the fault status bank ports
// assumes binding to fss_bank, one clock domain
`timescale 1ns/1ns
`default_nettype none
module fss_bank_sva
   import fss_pkg::*;
(
   // clock, reset, command and answer
   input wire logic            clk,
   input wire logic            reset,
   input wire logic            cmd_valid,
   input wire logic [1:0]      cmd_op,
   input wire logic [7:0]      cmd_code,
   input wire logic [15:0]     cmd_wdata,
   input wire logic [7:0]      page_sel,
   input wire logic            rsp_valid,
   input wire logic [15:0]     rsp_data,
   input wire logic            rsp_word,
   input wire logic            rsp_refused,
   // conditions and outputs
   input wire logic [3:0][7:0] vout_cond,
   input wire logic [3:0][7:0] iout_cond,
   input wire logic [3:0][7:0] temp_cond,
   input wire logic [3:0][7:0] vendor_cond,
   input wire logic [7:0]      input_cond,
   input wire logic [7:0]      cml_cond,
   input wire logic            busy_cmd_seen,
   input wire logic [3:0]      shared_fault0_shutoff,
   input wire logic [3:0]      shared_fault1_shutoff,
   input wire logic [15:0]     pad_write_value,
   input wire logic            alert_out_n_oe
);
   // any live condition may legally pull the alert again
   wire logic any_cond = |{vout_cond, iout_cond, temp_cond, vendor_cond, input_cond,
      cml_cond, busy_cmd_seen, shared_fault0_shutoff, shared_fault1_shutoff};
   wire logic is_clear = cmd_valid && cmd_op == OP_SEND && cmd_code == CMD_CLEAR;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   sequence s_rd(logic [7:0] c);
      cmd_valid && cmd_op == OP_READ && cmd_code == c && page_sel < 8'h04;
   endsequence
   sequence s_ans;
      rsp_valid && !rsp_refused;
   endsequence
   property p_clear_release; is_clear && !any_cond |=> s_ans ##0 !alert_out_n_oe; endproperty
   a_clear_release: assert property (p_clear_release) else $error("alert kept");
   property p_refire; is_clear && |(input_cond & INPUT_MASK) |=> alert_out_n_oe; endproperty
   a_refire: assert property (p_refire) else $error("alert not renewed");
   property p_hold; alert_out_n_oe && !is_clear |=> alert_out_n_oe; endproperty
   a_hold: assert property (p_hold) else $error("alert dropped");
   property p_shared; |{shared_fault0_shutoff, shared_fault1_shutoff} |=> alert_out_n_oe; endproperty
   a_shared: assert property (p_shared) else $error("no alert on shutoff");
   property p_word; s_rd(CMD_SUM_WORD) |=> s_ans ##0 rsp_word && rsp_data[10:8] == 3'h0; endproperty
   a_word: assert property (p_word) else $error("bad word answer");
   property p_byte; s_rd(CMD_SUM_BYTE) |=> s_ans ##0 !rsp_word && rsp_data[15:8] == 8'h00; endproperty
   a_byte: assert property (p_byte) else $error("bad byte answer");
   property p_global; cmd_valid && cmd_op == OP_READ && cmd_code == CMD_SUM_WORD
      && page_sel == PAGE_ALL |=> rsp_refused && rsp_data == 16'h0000; endproperty
   a_global: assert property (p_global) else $error("global read taken");
   property p_pads; cmd_valid && cmd_op == OP_WRITE && cmd_code == CMD_PADS
      |=> s_ans ##0 pad_write_value == $past(cmd_wdata); endproperty
   a_pads: assert property (p_pads) else $error("pad write lost");
   property p_send; cmd_valid && cmd_op == OP_SEND && cmd_code != CMD_CLEAR |=> rsp_refused; endproperty
   a_send: assert property (p_send) else $error("bad send taken");
endmodule
`default_nettype wire

// ### verification/fss_bank_tb.sv
// self-checking bench for the fault status bank with a host model
// assumes answers one cycle after each command edge
`timescale 1ns/1ns
`default_nettype none
module fss_bank_tb
   import fss_pkg::*;
;
   logic            clk, reset, cmd_valid, rsp_valid, rsp_word, rsp_refused, busy_cmd_seen;
   logic            alert_o, alert_oe;
   logic [1:0]      cmd_op;
   logic [7:0]      cmd_code, page_sel, input_cond, cml_cond, common_status;
   logic [15:0]     cmd_wdata, rsp_data, pad_pins, pad_write_value;
   logic [3:0][7:0] vout_cond, iout_cond, temp_cond, vendor_cond;
   logic [3:0]      sf0, sf1, chan_off, pg_en, pg_out;
   int              mismatches, cmp_count, cycles;
   // pull-up
   wire logic alert_n = alert_oe ? alert_o : 1'b1;
   localparam logic [23:0] BAD_TAB [6] = '{24'h0179ff, 24'h017804, 24'h015500,
      24'h000400, 24'h027a00, 24'h037900};
   fss_bank dut (.clk, .reset, .cmd_valid, .cmd_op, .cmd_code, .cmd_wdata, .page_sel,
      .rsp_valid, .rsp_data, .rsp_word, .rsp_refused, .vout_cond, .iout_cond, .temp_cond,
      .vendor_cond, .input_cond, .cml_cond, .busy_cmd_seen, .shared_fault0_shutoff(sf0),
      .shared_fault1_shutoff(sf1), .chan_output_off(chan_off), .power_good_enable(pg_en),
      .power_good_out(pg_out), .pad_pins, .pad_write_value, .common_status,
      .alert_out_n(alert_o), .alert_out_n_oe(alert_oe));
   fss_host host (.clk, .cmd_valid, .cmd_op, .cmd_code, .cmd_wdata, .page_sel, .rsp_valid,
      .rsp_data, .rsp_refused);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [1:0] op, input logic [7:0] code, input logic [7:0] pg,
      input logic [15:0] wd, input logic [15:0] exp, input logic exp_rf);
      logic [15:0] d;
      logic        rf;
      logic        ok;
      host.xfer(op, code, wd, pg, d, rf, ok);
      chk({14'h0, ok, rf}, {14'h0, 1'b1, exp_rf});
      chk(d, exp);
   endtask
   task automatic t_idle();
      cmd(OP_READ, CMD_SUM_WORD, 8'h00, 16'h0, 16'h0000, 1'b0);
      chk({15'h0, alert_n}, 16'h0001);
      cmd(OP_READ, CMD_PADS, PAGE_ALL, 16'h0, 16'ha5c3, 1'b0);
      cmd(OP_WRITE, CMD_PADS, PAGE_ALL, 16'h3c5a, 16'h0000, 1'b0);
      chk(pad_write_value, 16'h3c5a);
      cmd(OP_READ, CMD_COMMON, 8'h00, 16'h0, 16'h005e, 1'b0);
      $display("test idle done");
   endtask
   task automatic t_flags();
      @(posedge clk);
      vout_cond <= {8'h00, 8'h03, 8'h80, 8'h40};
      iout_cond[1] <= 8'h80;
      temp_cond[1] <= 8'h10;
      vendor_cond[1] <= 8'h04;
      {input_cond, cml_cond, busy_cmd_seen} <= {8'h10, 8'h01, 1'b1};
      @(posedge clk);
      {vout_cond, iout_cond, temp_cond, vendor_cond} <= '0;
      {input_cond, cml_cond, busy_cmd_seen} <= '0;
      @(posedge clk);
      chk({15'h0, alert_n}, 16'h0000);
      cmd(OP_READ, CMD_SUM_WORD, 8'h01, 16'h0, 16'hf0bf, 1'b0);
      cmd(OP_READ, CMD_SUM_BYTE, 8'h01, 16'h0, 16'h00bf, 1'b0);
      cmd(OP_READ, CMD_VOUT, 8'h01, 16'h0, 16'h0080, 1'b0);
      cmd(OP_READ, CMD_IOUT, 8'h01, 16'h0, 16'h0080, 1'b0);
      cmd(OP_READ, CMD_TEMP, 8'h01, 16'h0, 16'h0010, 1'b0);
      cmd(OP_READ, CMD_VENDOR, 8'h01, 16'h0, 16'h0004, 1'b0);
      cmd(OP_READ, CMD_INPUT, PAGE_ALL, 16'h0, 16'h0010, 1'b0);
      cmd(OP_READ, CMD_CML, 8'h02, 16'h0, 16'h0001, 1'b0);
      cmd(OP_READ, CMD_SUM_WORD, 8'h00, 16'h0, 16'ha08b, 1'b0);
      cmd(OP_READ, CMD_VOUT, 8'h02, 16'h0, 16'h0000, 1'b0);
      cmd(OP_READ, CMD_SUM_WORD, 8'h02, 16'h0, 16'h208b, 1'b0);
      $display("test flags done");
   endtask
   task automatic t_clear();
      cmd(OP_SEND, CMD_CLEAR, 8'h01, 16'h0, 16'h0000, 1'b0);
      chk({15'h0, alert_n}, 16'h0001);
      cmd(OP_READ, CMD_SUM_WORD, 8'h01, 16'h0, 16'h0000, 1'b0);
      cmd(OP_READ, CMD_SUM_WORD, 8'h00, 16'h0, 16'h8001, 1'b0);
      cmd(OP_SEND, CMD_CLEAR, PAGE_ALL, 16'h0, 16'h0000, 1'b0);
      cmd(OP_READ, CMD_SUM_WORD, 8'h00, 16'h0, 16'h0000, 1'b0);
      @(posedge clk);
      {temp_cond[2], input_cond} <= {8'h20, 8'h80};
      cmd(OP_SEND, CMD_CLEAR, PAGE_ALL, 16'h0, 16'h0000, 1'b0);
      chk({15'h0, alert_n}, 16'h0000);
      cmd(OP_READ, CMD_TEMP, 8'h02, 16'h0, 16'h0020, 1'b0);
      @(posedge clk);
      {temp_cond, input_cond} <= '0;
      cmd(OP_SEND, CMD_CLEAR, PAGE_ALL, 16'h0, 16'h0000, 1'b0);
      chk({15'h0, alert_n}, 16'h0001);
      $display("test clear done");
   endtask
   task automatic t_power();
      @(posedge clk);
      {pg_en[3], chan_off[3]} <= 2'b11;
      cmd(OP_READ, CMD_SUM_WORD, 8'h03, 16'h0, 16'h0841, 1'b0);
      cmd(OP_SEND, CMD_CLEAR, PAGE_ALL, 16'h0, 16'h0000, 1'b0);
      cmd(OP_READ, CMD_SUM_WORD, 8'h03, 16'h0, 16'h0841, 1'b0);
      @(posedge clk);
      {pg_out[3], chan_off[3]} <= 2'b10;
      cmd(OP_READ, CMD_SUM_WORD, 8'h03, 16'h0, 16'h0000, 1'b0);
      $display("test power done");
   endtask
   task automatic t_shared();
      cmd(OP_SEND, CMD_CLEAR, PAGE_ALL, 16'h0, 16'h0000, 1'b0);
      @(posedge clk);
      sf1[2] <= 1'b1;
      @(posedge clk);
      {sf1[2], sf0[0]} <= 2'b01;
      @(posedge clk);
      sf0[0] <= 1'b0;
      @(posedge clk);
      chk({15'h0, alert_n}, 16'h0000);
      cmd(OP_READ, CMD_VENDOR, 8'h02, 16'h0, 16'h0002, 1'b0);
      cmd(OP_READ, CMD_VENDOR, 8'h00, 16'h0, 16'h0001, 1'b0);
      cmd(OP_READ, CMD_SUM_WORD, 8'h02, 16'h0, 16'h1001, 1'b0);
      $display("test shared done");
   endtask
   task automatic t_refuse();
      for (int i = 0; i < 6; i++)
         cmd(BAD_TAB[i][17:16], BAD_TAB[i][15:8], BAD_TAB[i][7:0], 16'h0, 16'h0, 1'b1);
      $display("test refuse done");
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         mismatches++;
         end_sim();
      end
   end
   initial
   begin
      reset = 1'b1;
      {vout_cond, iout_cond, temp_cond, vendor_cond} = '0;
      {input_cond, cml_cond, busy_cmd_seen, sf0, sf1, chan_off, pg_en, pg_out} = '0;
      pad_pins = 16'ha5c3;
      common_status = 8'h5e;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_idle();
      t_flags();
      t_clear();
      t_power();
      t_shared();
      t_refuse();
      end_sim();
   end
endmodule
bind fss_bank fss_bank_sva sva (.clk, .reset, .cmd_valid, .cmd_op, .cmd_code, .cmd_wdata,
   .page_sel, .rsp_valid, .rsp_data, .rsp_word, .rsp_refused, .vout_cond, .iout_cond,
   .temp_cond, .vendor_cond, .input_cond, .cml_cond, .busy_cmd_seen, .shared_fault0_shutoff,
   .shared_fault1_shutoff, .pad_write_value, .alert_out_n_oe);
`default_nettype wire

// ### verification/fss_host.sv
// host model: one command per call, answer collected
// assumes the bank answers exactly one cycle after the command edge
`timescale 1ns/1ns
`default_nettype none
module fss_host
(
   // clock
   input  wire logic        clk,
   // command port
   output logic             cmd_valid,
   output logic [1:0]       cmd_op,
   output logic [7:0]       cmd_code,
   output logic [15:0]      cmd_wdata,
   output logic [7:0]       page_sel,
   // answer
   input  wire logic        rsp_valid,
   input  wire logic [15:0] rsp_data,
   input  wire logic        rsp_refused
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_op = 2'h0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
      page_sel = 8'h00;
   end
   task automatic xfer(input logic [1:0] op, input logic [7:0] code, input logic [15:0] wd,
      input logic [7:0] pg, output logic [15:0] d, output logic rf, output logic ok);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_code <= code;
      cmd_wdata <= wd;
      page_sel <= pg;
      @(posedge clk);
      cmd_valid <= 1'b0;
      // idle code and write data lines show the inverse
      cmd_code <= ~code;
      cmd_wdata <= ~wd;
      @(posedge clk);
      d = rsp_data;
      rf = rsp_refused;
      ok = rsp_valid;
   endtask
endmodule
`default_nettype wire
